// ===== hdl/sca_defs.vh
// constants of the switch cell assembler
`ifndef SCA_DEFS_VH
`define SCA_DEFS_VH
`define SCA_NPORT        4
`define SCA_LB_PORT      2'd3
`define SCA_CELL_WORDS   3'd4
`define SCA_IFH_BYTES    6'd36
`define SCA_MIN_FRAME    16'h0040
`define SCA_LEAD_WORDS   4'h2
`define SCA_STK_TYPE     16'h8880
`define SCA_INJ_WORD     32'h8880_000B
`define SCA_CTRL_TYPE    16'h8808
`define SCA_OP_PAUSE     16'h0001
`define SCA_OP_PFC       16'h0101
`define SCA_CTRL_DA_HI   32'h0180_C200
`define SCA_CTRL_DA_LO   16'h0001
`define SCA_CLK_NS       20
`define SCA_AGE_NS       200000
// register byte offsets
`define SCA_REG_SETUP0   8'h00
`define SCA_REG_STICKY   8'h10
`define SCA_REG_MASK     8'h14
`define SCA_REG_STAT0    8'h20
// port_setup fields
`define SCA_F_NOLEAD     0
`define SCA_F_DROPLEAD   1
`define SCA_F_FILL       2
`define SCA_F_POL_LO     3
`define SCA_F_SEL_LO     5
`define SCA_F_STACK      7
`define SCA_F_STATDIS    8
`define SCA_SETUP_RST    9'h000
// port_sticky_status fields
`define SCA_S_PREFIX_LO  0
`define SCA_S_AGED_LO    4
// injection prefix and drop policy codes
`define SCA_SEL_NONE     2'h0
`define SCA_SEL_SHORT    2'h1
`define SCA_SEL_LONG     2'h2
`define SCA_POL_NONE     2'h0
`define SCA_POL_DROPBAD  2'h1
`define SCA_POL_DROPGOOD 2'h2
`endif

// ===== hdl/sca_cell_assembler.v
// switch cell assembler: word bus and loopback into cells, pause, pfc, stats, wishbone registers
`timescale 1ns/1ps
`include "sca_defs.vh"
// Operation
// - pack port words into cells on cell bus
// - loopback from rewriter enters as a port
// - first cell reserves 36-byte frame header
// - stacking port tag moved into header
// - detected stack header stripped into header
// - serve ports in queue system calendar order
// - pause frames forwarded to disassembler
// - pfc priority pause forwarded to queues
// - count statistics for low-speed ports only
// - preamble expected unless no-lead-in set
// - fill enabled pads short frames to 64
// - unfinished frame closed by aborted eof cell
// - aged fragment sets per-port sticky bit
// - injection prefix mismatch sets sticky bit
// - prefix select long, short or none
// - drop policy none, non-compliant, compliant
// - drop-lead-in discards preamble before injection
module sca_cell_assembler #(
   parameter AGE_CYCLES = `SCA_AGE_NS / `SCA_CLK_NS
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         wb_cyc_i,
   input  wire         wb_stb_i,
   input  wire         wb_we_i,
   input  wire [7:0]   wb_adr_i,
   input  wire [3:0]   wb_sel_i,
   input  wire [31:0]  wb_dat_i,
   output reg  [31:0]  wb_dat_o,
   output reg          wb_ack_o,
   output wire         irq,
   input  wire         inValid,
   input  wire [1:0]   inPort,
   input  wire [31:0]  inData,
   input  wire         inSof,
   input  wire         inEof,
   input  wire [1:0]   inBytes,
   output wire         inReady,
   input  wire         lbValid,
   input  wire [31:0]  lbData,
   input  wire         lbSof,
   input  wire         lbEof,
   input  wire [1:0]   lbBytes,
   output wire         lbReady,
   input  wire [3:0]   portDown,
   input  wire [3:0]   portLowSpeed,
   input  wire         calValid,
   input  wire [1:0]   calPort,
   output wire         calReady,
   output reg          cellValid,
   input  wire         cellReady,
   output reg  [1:0]   cellPort,
   output reg  [127:0] cellData,
   output reg  [2:0]   cellWords,
   output reg          cellSof,
   output reg          cellEof,
   output reg          cellAbort,
   output reg          cellInject,
   output reg  [5:0]   cellHdrRoom,
   output reg  [31:0]  cellStackTag,
   output reg  [15:0]  cellFrameBytes,
   output reg          pauseValid,
   output reg  [1:0]   pausePort,
   output reg  [15:0]  pauseQuanta,
   output reg          pfcValid,
   output reg  [1:0]   pfcPort,
   output reg  [7:0]   pfcPrioMask,
   output reg  [15:0]  pfcTime
);
   integer i;
   integer j;
   integer k;
   reg  [8:0]  setup_q [0:3];
   reg  [7:0]  sticky_q;
   reg  [7:0]  mask_q;
   reg  [31:0] stat_q [0:3];
   reg  [31:0] mem_q [0:15];
   reg  [3:0]  actv_q, pend_q, pSof_q, pEof_q, pAbt_q, pInj_q;
   reg  [3:0]  sofSeen_q, stk_q, inj_q, bad_q, ctl_q;
   reg  [1:0]  fill_q [0:3];
   reg  [3:0]  widx_q [0:3];
   reg  [15:0] bytes_q [0:3];
   reg  [2:0]  pCnt_q [0:3];
   reg  [15:0] pLen_q [0:3];
   reg  [31:0] tag_q [0:3];
   reg  [15:0] op_q [0:3];
   wire [3:0]  ageHit;

   // source select: loopback has priority over the port word bus
   wire        useLb  = lbValid;
   wire [1:0]  src    = useLb ? `SCA_LB_PORT : inPort;
   wire [31:0] wData  = useLb ? lbData : inData;
   wire        wSof   = useLb ? lbSof : inSof;
   wire        wEof   = useLb ? lbEof : inEof;
   wire [1:0]  wBytes = useLb ? lbBytes : inBytes;
   wire        acc    = (useLb || inValid) && !pend_q[src];
   assign lbReady = !pend_q[`SCA_LB_PORT];
   assign inReady = !useLb && !pend_q[inPort];

   // per-port configuration of the current source
   wire [8:0] cfg     = setup_q[src];
   wire [1:0] injSel  = cfg[`SCA_F_SEL_LO+1:`SCA_F_SEL_LO];
   wire [1:0] injPol  = cfg[`SCA_F_POL_LO+1:`SCA_F_POL_LO];
   wire       strip   = !cfg[`SCA_F_NOLEAD] || (cfg[`SCA_F_DROPLEAD] && injSel != `SCA_SEL_NONE);
   wire [3:0] widx    = wSof ? 4'h0 : widx_q[src];
   wire [3:0] eIdx    = widx - (strip ? `SCA_LEAD_WORDS : 4'h0);
   wire       inLead  = strip && (widx < `SCA_LEAD_WORDS);
   wire       stkNow  = cfg[`SCA_F_STACK] && injSel == `SCA_SEL_NONE && eIdx == 4'h3
                        && wData[31:16] == `SCA_STK_TYPE;
   wire       stkMode = !wSof && stk_q[src];
   wire       inStk   = stkNow || (stkMode && (eIdx == 4'h4 || eIdx == 4'h5));
   wire       chkNow  = !inLead && ((injSel == `SCA_SEL_SHORT && eIdx == 4'h3) ||
                        (injSel == `SCA_SEL_LONG && eIdx == 4'h4));
   wire       drop    = inLead || inStk || (acc && !wSof && !actv_q[src]);
   wire [1:0] fill    = wSof ? 2'd0 : fill_q[src];
   wire [15:0] addB   = (wEof && wBytes != 2'd0) ? {14'h0000, wBytes} : 16'h0004;
   wire [15:0] newLen = (wSof ? 16'h0000 : bytes_q[src]) + (drop ? 16'h0000 : addB);
   wire [15:0] padLen = (cfg[`SCA_F_FILL] && newLen < `SCA_MIN_FRAME) ? `SCA_MIN_FRAME : newLen;
   wire       injBad  = chkNow && wData != `SCA_INJ_WORD;
   wire       badFrm  = injBad || (!wSof && bad_q[src]);
   wire       goodFrm = (chkNow && !injBad) || (!wSof && inj_q[src]);
   wire       polDrop = (injPol == `SCA_POL_DROPBAD && badFrm) ||
                        (injPol == `SCA_POL_DROPGOOD && goodFrm);
   wire       ctlNow  = !inLead && eIdx == 4'h3 && wData[31:16] == `SCA_CTRL_TYPE &&
                        (wSof ? 1'b0 : ctl_q[src]);
   wire       cellFull = !drop && fill == (`SCA_CELL_WORDS - 3'd1);

   // per-port fragment ageing counters
   genvar g;
   generate
      for (g = 0; g < `SCA_NPORT; g = g + 1) begin : gAge
         reg [15:0] age_q;
         always @(posedge clk) begin
            if (rst || !actv_q[g] || (acc && src == g))
               age_q <= 16'h0000;
            else if (age_q != AGE_CYCLES[15:0])
               age_q <= age_q + 16'h0001;
         end
         assign ageHit[g] = actv_q[g] && (portDown[g] || age_q == AGE_CYCLES[15:0]);
      end
   endgenerate

   // calendar driven cell output
   wire outFree = !cellValid || cellReady;
   wire load    = outFree && calValid && pend_q[calPort];
   assign calReady = outFree;

   // wishbone slave, one wait state
   wire        wbReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire        wbWr   = wbReq && wb_we_i;
   wire [31:0] wMask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wbVal  = wb_dat_i & wMask;
   wire        isSet  = wb_adr_i[7:4] == 4'h0;
   wire        isStat = wb_adr_i[7:4] == 4'h2;
   wire [1:0]  rIdx   = wb_adr_i[3:2];
   reg  [7:0]  stSet;
   reg  [3:0]  statInc;

   assign irq = |(sticky_q & mask_q);

   always @* begin
      stSet   = 8'h00;
      statInc = 4'h0;
      if (acc && injBad)
         stSet[`SCA_S_PREFIX_LO + src] = 1'b1;
      // policy-dropped frames are not counted as good frames
      if (acc && wEof && (wSof || actv_q[src]) && !drop && !polDrop && portLowSpeed[src] &&
          !cfg[`SCA_F_STATDIS])
         statInc[src] = 1'b1;
      for (i = 0; i < `SCA_NPORT; i = i + 1)
         if (ageHit[i] && !pend_q[i] && !(acc && src == i))
            stSet[`SCA_S_AGED_LO + i] = 1'b1;
   end

   always @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         sticky_q <= 8'h00;
         mask_q   <= 8'h00;
         for (j = 0; j < `SCA_NPORT; j = j + 1) begin
            setup_q[j] <= `SCA_SETUP_RST;
            stat_q[j]  <= 32'h0000_0000;
         end
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= 32'h0000_0000;
         if (wbReq && !wb_we_i) begin
            if (isSet)
               wb_dat_o <= {23'h00_0000, setup_q[rIdx]};
            else if (isStat)
               wb_dat_o <= stat_q[rIdx];
            else if (wb_adr_i == `SCA_REG_STICKY)
               wb_dat_o <= {24'h00_0000, sticky_q};
            else if (wb_adr_i == `SCA_REG_MASK)
               wb_dat_o <= {24'h00_0000, mask_q};
         end
         if (wbWr && isSet)
            setup_q[rIdx] <= (setup_q[rIdx] & ~wMask[8:0]) | wbVal[8:0];
         if (wbWr && wb_adr_i == `SCA_REG_MASK)
            mask_q <= (mask_q & ~wMask[7:0]) | wbVal[7:0];
         // set wins over a same-cycle write-one clear
         sticky_q <= (sticky_q & ~((wbWr && wb_adr_i == `SCA_REG_STICKY) ? wbVal[7:0] : 8'h00))
                     | stSet;
         for (j = 0; j < `SCA_NPORT; j = j + 1) begin
            if (wbWr && isStat && rIdx == j)
               stat_q[j] <= (stat_q[j] & ~wMask) | wbVal;
            else if (statInc[j])
               stat_q[j] <= stat_q[j] + 32'h0000_0001;
         end
      end
   end

   // frame assembly per port
   always @(posedge clk) begin
      if (rst) begin
         actv_q      <= 4'h0;
         pend_q      <= 4'h0;
         pSof_q      <= 4'h0;
         pEof_q      <= 4'h0;
         pAbt_q      <= 4'h0;
         pInj_q      <= 4'h0;
         sofSeen_q   <= 4'h0;
         stk_q       <= 4'h0;
         inj_q       <= 4'h0;
         bad_q       <= 4'h0;
         ctl_q       <= 4'h0;
         pauseValid  <= 1'b0;
         pausePort   <= 2'h0;
         pauseQuanta <= 16'h0000;
         pfcValid    <= 1'b0;
         pfcPort     <= 2'h0;
         pfcPrioMask <= 8'h00;
         pfcTime     <= 16'h0000;
         for (k = 0; k < `SCA_NPORT; k = k + 1) begin
            fill_q[k]  <= 2'h0;
            widx_q[k]  <= 4'h0;
            bytes_q[k] <= 16'h0000;
            pCnt_q[k]  <= 3'h0;
            pLen_q[k]  <= 16'h0000;
            tag_q[k]   <= 32'h0000_0000;
            op_q[k]    <= 16'h0000;
         end
      end else begin
         pauseValid <= 1'b0;
         pfcValid   <= 1'b0;
         if (load)
            pend_q[calPort] <= 1'b0;
         for (k = 0; k < `SCA_NPORT; k = k + 1)
            if (ageHit[k] && !pend_q[k] && !(acc && src == k)) begin
               pend_q[k] <= 1'b1;
               pEof_q[k] <= 1'b1;
               pAbt_q[k] <= 1'b1;
               pSof_q[k] <= sofSeen_q[k];
               pInj_q[k] <= inj_q[k];
               pCnt_q[k] <= {1'b0, fill_q[k]};
               pLen_q[k] <= bytes_q[k];
               actv_q[k] <= 1'b0;
               fill_q[k] <= 2'd0;
            end
         if (acc && !(drop && !wSof && !actv_q[src])) begin
            if (wSof) begin
               sofSeen_q[src] <= 1'b1;
               stk_q[src] <= 1'b0;
               inj_q[src] <= 1'b0;
               bad_q[src] <= 1'b0;
               tag_q[src] <= 32'h0000_0000;
            end
            actv_q[src]  <= !wEof;
            widx_q[src]  <= (widx == 4'hF) ? widx : widx + 4'h1;
            bytes_q[src] <= newLen;
            if (stkNow)
               stk_q[src] <= 1'b1;
            if (stkMode && eIdx == 4'h4)
               tag_q[src] <= wData;
            if (injBad)
               bad_q[src] <= 1'b1;
            if (chkNow && !injBad)
               inj_q[src] <= 1'b1;
            // control frame recognition on destination address and type
            if (!inLead && eIdx == 4'h0)
               ctl_q[src] <= wData == `SCA_CTRL_DA_HI;
            if (!inLead && eIdx == 4'h1)
               ctl_q[src] <= ctl_q[src] && wData[31:16] == `SCA_CTRL_DA_LO;
            if (ctlNow)
               op_q[src] <= wData[15:0];
            if (!inLead && eIdx == 4'h4 && ctl_q[src] && op_q[src] == `SCA_OP_PAUSE && !wSof) begin
               pauseValid  <= 1'b1;
               pausePort   <= src;
               pauseQuanta <= wData[31:16];
            end
            if (!inLead && eIdx == 4'h4 && ctl_q[src] && op_q[src] == `SCA_OP_PFC && !wSof) begin
               pfcValid    <= 1'b1;
               pfcPort     <= src;
               pfcPrioMask <= wData[23:16];
               pfcTime     <= wData[15:0];
            end
            if (ctlNow == 1'b0 && !inLead && eIdx == 4'h3)
               ctl_q[src] <= 1'b0;
            if (!drop)
               mem_q[{src, fill}] <= wData;
            fill_q[src] <= (cellFull || wEof) ? 2'd0 : fill + (drop ? 2'd0 : 2'd1);
            if (cellFull || wEof) begin
               pend_q[src] <= 1'b1;
               pSof_q[src] <= wSof || sofSeen_q[src];
               sofSeen_q[src] <= 1'b0;
               pEof_q[src] <= wEof;
               pAbt_q[src] <= wEof && polDrop;
               pInj_q[src] <= goodFrm;
               pCnt_q[src] <= {1'b0, fill} + (drop ? 3'd0 : 3'd1);
               pLen_q[src] <= wEof ? padLen : newLen;
            end
         end
      end
   end

   // output stage
   always @(posedge clk) begin
      if (rst) begin
         cellValid      <= 1'b0;
         cellPort       <= 2'h0;
         cellData       <= 128'h0;
         cellWords      <= 3'h0;
         cellSof        <= 1'b0;
         cellEof        <= 1'b0;
         cellAbort      <= 1'b0;
         cellInject     <= 1'b0;
         cellHdrRoom    <= 6'h00;
         cellStackTag   <= 32'h0000_0000;
         cellFrameBytes <= 16'h0000;
      end else if (outFree) begin
         cellValid <= load;
         if (load) begin
            cellPort       <= calPort;
            cellData       <= {mem_q[{calPort, 2'd0}], mem_q[{calPort, 2'd1}],
                               mem_q[{calPort, 2'd2}], mem_q[{calPort, 2'd3}]};
            cellWords      <= pCnt_q[calPort];
            cellSof        <= pSof_q[calPort];
            cellEof        <= pEof_q[calPort];
            cellAbort      <= pAbt_q[calPort];
            cellInject     <= pInj_q[calPort];
            cellHdrRoom    <= pSof_q[calPort] ? `SCA_IFH_BYTES : 6'd0;
            cellStackTag   <= tag_q[calPort];
            cellFrameBytes <= pLen_q[calPort];
         end
      end
   end
endmodule // sca_cell_assembler

// ===== dv/sca_cell_assembler_assertions.sv
// port assertions of the switch cell assembler and their bind
`timescale 1ns/1ps
module sca_cell_assembler_checker #(
   parameter AGE_CYCLES = 50
) (
   input wire         clk,
   input wire         rst,
   input wire         wb_cyc_i,
   input wire         wb_stb_i,
   input wire         wb_ack_o,
   input wire         lbValid,
   input wire         inReady,
   input wire         calValid,
   input wire [1:0]   calPort,
   input wire         cellValid,
   input wire         cellReady,
   input wire [1:0]   cellPort,
   input wire [127:0] cellData,
   input wire [2:0]   cellWords,
   input wire         cellSof,
   input wire         cellEof,
   input wire         cellAbort,
   input wire [5:0]   cellHdrRoom,
   input wire [15:0]  cellFrameBytes,
   input wire         pauseValid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_ack_after_take:
   assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack timing");
   a_cell_held_stall:
   assert property (cellValid && !cellReady |=> cellValid && $stable(cellData) && $stable(cellPort)
      && $stable(cellFrameBytes)) else $error("stalled cell changed");
   a_cell_full_words:
   assert property (cellValid && !cellEof |-> cellWords == 3'h4) else $error("short middle cell");
   a_sof_hdr_room:
   assert property (cellValid |-> cellHdrRoom == (cellSof ? 6'h24 : 6'h00)) else $error("wrong header room");
   a_cal_port_order:
   assert property (cellValid && (!$past(cellValid) || $past(cellReady)) |-> $past(calValid)
      && cellPort == $past(calPort)) else $error("cell port off calendar");
   a_abort_ends_frame:
   assert property (cellValid && cellAbort |-> cellEof) else $error("abort without eof");
   a_pause_one_pulse:
   assert property (pauseValid |=> !pauseValid) else $error("pause pulse too long");
   a_loop_first:
   assert property (lbValid |-> !inReady) else $error("port bus not held off");
endmodule // sca_cell_assembler_checker

bind sca_cell_assembler sca_cell_assembler_checker #(.AGE_CYCLES(AGE_CYCLES)) u_chk (
   .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .lbValid, .inReady, .calValid, .calPort,
   .cellValid, .cellReady, .cellPort, .cellData, .cellWords, .cellSof, .cellEof, .cellAbort,
   .cellHdrRoom, .cellFrameBytes, .pauseValid
);

// ===== dv/sca_far_side.sv
// queue system calendar and cell sink facing the assembler
`timescale 1ns/1ps
module sca_far_side (
   input  wire        clk,
   input  wire        rst,
   input  wire        calReady,
   output logic       calValid,
   output logic [1:0] calPort,
   output logic       cellReady
);
   always @(posedge clk) begin
      if (rst) begin
         calValid  <= 1'b0;
         calPort   <= 2'h0;
         cellReady <= 1'b0;
      end else begin
         cellReady <= $urandom_range(3) != 0;
         // a slot is held until the assembler takes it
         if (!calValid || calReady) begin
            calValid <= $urandom_range(7) != 0;
            calPort  <= calPort + 2'h1;
         end
      end
   end
endmodule // sca_far_side

// ===== dv/sca_cell_assembler_tb.sv
// self-checking testbench of the switch cell assembler
`timescale 1ns/1ps
`include "sca_defs.vh"
module sca_cell_assembler_tb;
   logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, inValid, inSof, inEof, lbValid, lbSof, lbEof;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, portDown, portLowSpeed;
   logic [31:0] wb_dat_i, inData, lbData;
   logic [1:0]  inPort, inBytes, lbBytes;
   wire         wb_ack_o, irq, inReady, lbReady, calValid, calReady, cellValid, cellReady, cellSof, cellEof;
   wire         cellAbort, cellInject, pauseValid, pfcValid;
   wire [31:0]  wb_dat_o, cellStackTag;
   wire [1:0]   calPort, cellPort, pausePort, pfcPort;
   wire [127:0] cellData;
   wire [2:0]   cellWords;
   wire [5:0]   cellHdrRoom;
   wire [7:0]   pfcPrioMask;
   wire [15:0]  cellFrameBytes, pauseQuanta, pfcTime;
   logic [31:0] w [0:7];
   logic [94:0] cellQ [$];
   logic [26:0] evQ [$];
   logic [31:0] regQ [$];
   int          fails, num_checks;

   sca_cell_assembler #(.AGE_CYCLES(50)) dut (.*);
   sca_far_side far (.clk, .rst, .calReady, .calValid, .calPort, .cellReady);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic tally(input logic bad, input logic [94:0] got, exp);
      num_checks++;
      if (bad) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmpCell(input logic [94:0] got, exp);
      tally(got !== exp, got, exp);
   endtask
   task automatic cmpEv(input logic [26:0] got, exp);
      tally(got !== exp, got, exp);
   endtask
   task automatic cmpReg(input logic [31:0] got, exp);
      tally(got !== exp, got, exp);
   endtask

   always @(posedge clk) begin
      if (cellValid && cellReady)
         cmpCell({cellPort, cellWords, cellSof, cellEof, cellAbort, cellHdrRoom, cellFrameBytes, cellData[127:96],
            cellInject, cellStackTag}, cellQ.pop_front());
      if (pauseValid)
         cmpEv({1'b0, pausePort, 8'h00, pauseQuanta}, evQ.pop_front());
      if (pfcValid)
         cmpEv({1'b1, pfcPort, pfcPrioMask, pfcTime}, evQ.pop_front());
      if (wb_ack_o && !wb_we_i)
         cmpReg(wb_dat_o, regQ.pop_front());
   end

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= wr;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk); while (!wb_ack_o);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      regQ.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   // port 3 is the loopback source
   task automatic frame(input logic [1:0] p, input int n, input logic close);
      for (int i = 0; i < n; i++) begin
         if (p == 2'h3) begin
            lbValid <= 1'b1;
            lbData  <= w[i];
            lbSof   <= i == 0;
            lbEof   <= close && i == n - 1;
         end else begin
            inValid <= 1'b1;
            inPort  <= p;
            inData  <= w[i];
            inSof   <= i == 0;
            inEof   <= close && i == n - 1;
         end
         do @(posedge clk); while (!(p == 2'h3 ? lbReady : inReady));
      end
      inValid <= 1'b0;
      lbValid <= 1'b0;
      inData  <= ~inData;
      lbData  <= ~lbData;
      @(posedge clk);
   endtask
   task automatic drain;
      for (int i = 0; i < 300 && cellQ.size() + evQ.size() != 0; i++)
         @(posedge clk);
      tally(cellQ.size() + evQ.size() != 0, cellQ.size(), 0);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #200_000;
      fails++;
      conclude;
   end

   initial begin
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, inValid, inSof, inEof, lbValid, lbSof, lbEof} = '0;
      {wb_adr_i, wb_dat_i, inData, lbData, inPort, inBytes, lbBytes, portDown} = '0;
      wb_sel_i = 4'hf;
      portLowSpeed = 4'h1;
      void'($urandom(58));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(`SCA_REG_SETUP0, 32'h0000_0000);
      rd(`SCA_REG_STICKY, 32'h0000_0000);
      rd(`SCA_REG_MASK, 32'h0000_0000);
      rd(8'h80, 32'h0000_0000);
      w[5] = $urandom;
      bus(1'b1, 8'h0c, w[5]);
      rd(8'h0c, w[5] & 32'h0000_01ff);
      bus(1'b1, 8'h0c, 32'h0000_0005);
      bus(1'b1, 8'h04, 32'h0000_0001);
      bus(1'b1, 8'h08, 32'h0000_0001);
      for (int i = 0; i < 6; i++)
         w[i] = $urandom;
      cellQ.push_back({2'h0, 3'h4, 3'h6, 6'h24, 16'h0010, w[2], 33'h0});
      frame(2'h0, 6, 1'b1);
      for (int k = 0; k < 2; k++) begin
         w[0] = `SCA_CTRL_DA_HI;
         w[1][31:16] = `SCA_CTRL_DA_LO;
         w[3] = {`SCA_CTRL_TYPE, k ? `SCA_OP_PFC : `SCA_OP_PAUSE};
         w[4] = $urandom;
         evQ.push_back(k ? {1'b1, 2'h1, w[4][23:16], w[4][15:0]} : {1'b0, 2'h1, 8'h00, w[4][31:16]});
         cellQ.push_back({2'h1, 3'h4, 3'h4, 6'h24, 16'h0010, w[0], 33'h0});
         cellQ.push_back({2'h1, 3'h1, 3'h2, 6'h00, 16'h0014, w[4], 33'h0});
         frame(2'h1, 5, 1'b1);
         drain;
      end
      w[0] = $urandom;
      cellQ.push_back({2'h1, 3'h1, 3'h7, 6'h24, 16'h0004, w[0], 33'h0});
      frame(2'h1, 1, 1'b0);
      portDown <= 4'h2;
      @(posedge clk);
      portDown <= 4'h0;
      drain;
      cellQ.push_back({2'h2, 3'h1, 3'h7, 6'h24, 16'h0004, w[0], 33'h0});
      frame(2'h2, 1, 1'b0);
      drain;
      rd(`SCA_REG_STICKY, 32'h0000_0060);
      bus(1'b1, `SCA_REG_MASK, 32'h0000_0020);
      cmpReg({31'h0000_0000, irq}, 32'h0000_0001);
      cellQ.push_back({2'h3, 3'h1, 3'h6, 6'h24, 16'h0040, w[0], 33'h0});
      frame(2'h3, 1, 1'b1);
      drain;
      rd(`SCA_REG_STICKY, 32'h0000_0060);
      rd(`SCA_REG_STAT0, 32'h0000_0001);
      rd(`SCA_REG_STAT0 + 8'h04, 32'h0000_0000);
      bus(1'b1, `SCA_REG_STICKY, 32'h0000_0020);
      rd(`SCA_REG_STICKY, 32'h0000_0040);
      cmpReg({31'h0000_0000, irq}, 32'h0000_0000);
      // stacking port: words 3..5 leave the frame, word 4 becomes the tag
      bus(1'b1, 8'h08, 32'h0000_0081);
      for (int i = 0; i < 8; i++)
         w[i] = $urandom;
      w[3][31:16] = `SCA_STK_TYPE;
      cellQ.push_back({2'h2, 3'h4, 3'h4, 6'h24, 16'h0010, w[0], 1'b0, w[4]});
      cellQ.push_back({2'h2, 3'h1, 3'h2, 6'h00, 16'h0014, w[7], 1'b0, w[4]});
      frame(2'h2, 8, 1'b1);
      drain;
      // short prefix, drop non-compliant: bad prefix then good prefix
      bus(1'b1, 8'h04, 32'h0000_0029);
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 5; i++)
            w[i] = $urandom;
         w[3] = k ? `SCA_INJ_WORD : ~`SCA_INJ_WORD;
         cellQ.push_back({2'h1, 3'h4, 3'h4, 6'h24, 16'h0010, w[0], k[0], 32'h0000_0000});
         cellQ.push_back({2'h1, 3'h1, 2'h1, ~k[0], 6'h00, 16'h0014, w[4], k[0], 32'h0000_0000});
         frame(2'h1, 5, 1'b1);
         drain;
      end
      rd(`SCA_REG_STICKY, 32'h0000_0042);
      conclude;
   end
endmodule // sca_cell_assembler_tb
